// [rtl/dvs_pkg.sv]
// Constants for the dynamic voltage scaling control block
package dvs_pkg;
   // -------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_FLOOR    = 8'h00;
   localparam logic [7:0] ADDR_ROOF     = 8'h01;
   localparam logic [7:0] ADDR_MODE     = 8'h02;
   localparam logic [7:0] ADDR_RAMP     = 8'h03;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int STEP_MSB      = 5;
   localparam int LIGHT_OPT_BIT = 6;
   localparam int SOFT_EN_BIT   = 7;
   localparam int RAMP_CODE_MSB = 2;
   localparam int STRATEGY_BIT  = 6;
   localparam int GO_BIT        = 7;
   localparam int FLOOR_MODE_LSB = 0;
   localparam int ROOF_MODE_LSB  = 2;

   // -------------------------------------------------------------
   // Reset values and encodings
   // -------------------------------------------------------------
   localparam logic [5:0] FLOOR_CODE_RST = 6'h00;
   localparam logic [5:0] ROOF_CODE_RST  = 6'h10;
   localparam logic       LIGHT_OPT_RST  = 1'b1;
   localparam logic       SOFT_EN_RST    = 1'b1;
   localparam logic [2:0] SINGLE_STEP    = 3'h7;
   localparam logic       STRATEGY_RST   = 1'b0;
   localparam logic [7:0] MODE_RST       = 8'h00;
   localparam logic [1:0] MODE_PWM       = 2'h0;

   // Step size in microvolts: 12500 standard, 25000 coarse variant
   localparam int STEP_UV_FINE   = 12500;
   localparam int STEP_UV_COARSE = 25000;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MICROSTEP_NS  = 1000;
   localparam int MICROSTEP_CYC = (MICROSTEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_RAMP = 3'b010,
      SEQ_DROP = 3'b100
   } seq_state_t;
endpackage : dvs_pkg

// [rtl/dvs_ctrl.sv]
// Output voltage selection, ramp sequencing, power good and enable gating
`timescale 1ns/1ps
`default_nettype none
module dvs_ctrl #(
   parameter int unsigned STEP_BASE_CYC = dvs_pkg::MICROSTEP_CYC
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Register port from the serial engine
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Pins and analog status
   input  wire logic       voltage_select_pin,
   input  wire logic       enable_pin,
   input  wire logic       output_undervolt,
   input  wire logic       pfm_pulsing,
   // Converter control
   output logic      [5:0] output_step_code,
   output logic            power_good_output,
   output logic            converter_on,
   output logic            light_skip_inductor_opt
);
   import dvs_pkg::*;

   // -------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   always_ff @(posedge clk) begin
      if (srst) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
      end else begin
         sync_a <= {pfm_pulsing, output_undervolt, enable_pin, voltage_select_pin};
         sync_b <= sync_a;
      end
   end
   wire voltage_select_pin_s  = sync_b[0];
   wire en_s    = sync_b[1];
   wire uv_s    = sync_b[2];
   wire pulse_s = sync_b[3];

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   logic [5:0] floor_step_code;
   logic [5:0] roof_step_code;
   logic       converter_soft_enable;
   logic [7:0] operating_mode_config;
   logic [2:0] ramp_rate_code;
   logic       scaling_strategy_select;
   logic       go;
   logic [5:0] sw_target;
   seq_state_t state;
   seq_state_t next_state;
   logic [15:0] tick;

   // Writes dropped while the enable pin is low
   wire wr_ok    = reg_wr && en_s;
   wire wr_floor = wr_ok && reg_addr == ADDR_FLOOR;
   wire wr_roof  = wr_ok && reg_addr == ADDR_ROOF;
   wire wr_voltage_select_pin  = wr_floor || wr_roof;
   wire wr_mode  = wr_ok && reg_addr == ADDR_MODE;
   wire wr_ramp  = wr_ok && reg_addr == ADDR_RAMP;

   wire hw_mode  = scaling_strategy_select;
   wire go_set   = wr_ramp && reg_wdata[GO_BIT] && !reg_wdata[STRATEGY_BIT];
   wire multi    = ramp_rate_code != SINGLE_STEP;

   // Target selection
   wire [5:0] hw_target = voltage_select_pin_s ? roof_step_code : floor_step_code;
   wire [5:0] target    = hw_mode ? hw_target : sw_target;
   wire [1:0] floor_mode = operating_mode_config[FLOOR_MODE_LSB +: 2];
   wire [1:0] roof_mode  = operating_mode_config[ROOF_MODE_LSB +: 2];
   wire [1:0] tgt_mode   = (hw_mode && !voltage_select_pin_s) ? floor_mode : roof_mode;
   wire       at_target  = output_step_code == target;
   wire       going_up   = target > output_step_code;
   wire       go_done    = go && state == SEQ_IDLE && at_target;

   // Micro-step spacing doubles for each code below the single-step code
   function automatic logic [15:0] step_gap(input logic [2:0] code);
      step_gap = 16'(STEP_BASE_CYC << (3'h6 - code));
   endfunction : step_gap

   always_ff @(posedge clk) begin
      if (srst) begin
         floor_step_code         <= FLOOR_CODE_RST;
         roof_step_code          <= ROOF_CODE_RST;
         light_skip_inductor_opt <= LIGHT_OPT_RST;
         converter_soft_enable   <= SOFT_EN_RST;
         operating_mode_config   <= MODE_RST;
         ramp_rate_code          <= SINGLE_STEP;
         scaling_strategy_select <= STRATEGY_RST;
      end else begin
         if (wr_floor) begin
            floor_step_code <= reg_wdata[STEP_MSB:0];
         end
         if (wr_roof) begin
            roof_step_code <= reg_wdata[STEP_MSB:0];
         end
         if (wr_voltage_select_pin) begin
            light_skip_inductor_opt <= reg_wdata[LIGHT_OPT_BIT];
            converter_soft_enable   <= reg_wdata[SOFT_EN_BIT];
         end
         if (wr_mode) begin
            operating_mode_config <= reg_wdata;
         end
         if (wr_ramp) begin
            ramp_rate_code          <= reg_wdata[RAMP_CODE_MSB:0];
            scaling_strategy_select <= reg_wdata[STRATEGY_BIT];
         end
      end
   end

   // A go write in the same cycle as completion keeps go set
   always_ff @(posedge clk) begin
      if (srst) begin
         go        <= 1'b0;
         sw_target <= ROOF_CODE_RST;
      end else begin
         if (go_set) begin
            go        <= 1'b1;
            sw_target <= roof_step_code;
         end else if (go_done || hw_mode) begin
            go <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------
   wire [7:0] voltage_select_pin_hi = {converter_soft_enable, light_skip_inductor_opt, 6'h00};
   wire [7:0] rd_mux =
      reg_addr == ADDR_FLOOR ? (voltage_select_pin_hi | {2'h0, floor_step_code}) :
      reg_addr == ADDR_ROOF  ? (voltage_select_pin_hi | {2'h0, roof_step_code})  :
      reg_addr == ADDR_MODE  ? operating_mode_config :
      reg_addr == ADDR_RAMP  ? {go, scaling_strategy_select, 3'h0, ramp_rate_code} :
      UNMAPPED_READ;

   always_ff @(posedge clk) begin
      if (srst) begin
         reg_rdata <= UNMAPPED_READ;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end

   // -------------------------------------------------------------
   // Ramp sequencer
   // -------------------------------------------------------------
   // Software strategy holds the present code until go is set
   wire want_move = !at_target && (hw_mode || go);
   wire tick_zero = tick == 16'h0000;

   always_comb begin
      next_state = state;
      case (state)
         SEQ_IDLE: begin
            if (want_move && multi) begin
               next_state = SEQ_RAMP;
            end else if (want_move && !going_up && tgt_mode != MODE_PWM) begin
               next_state = SEQ_DROP;
            end
         end
         SEQ_RAMP: begin
            if (!multi || (tick_zero && (output_step_code + (going_up ? 6'h1 : 6'h3f)) == target)
                || at_target) begin
               next_state = SEQ_IDLE;
            end
         end
         SEQ_DROP: begin
            if (pulse_s) begin
               next_state = SEQ_IDLE;
            end
         end
         default: next_state = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state            <= SEQ_IDLE;
         tick             <= 16'h0000;
         output_step_code <= FLOOR_CODE_RST;
      end else begin
         state <= next_state;
         if (state == SEQ_IDLE && want_move) begin
            tick <= step_gap(ramp_rate_code);
            if (!multi) begin
               output_step_code <= target;
            end
         end else if (state == SEQ_RAMP && !at_target) begin
            if (tick_zero) begin
               tick             <= step_gap(ramp_rate_code);
               output_step_code <= going_up ? output_step_code + 6'h1
                                            : output_step_code - 6'h1;
            end else begin
               tick <= tick - 16'h0001;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Power good and enable
   // -------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         power_good_output <= 1'b0;
         converter_on      <= 1'b0;
      end else begin
         power_good_output <= next_state == SEQ_IDLE && state == SEQ_IDLE
                              && !uv_s;
         converter_on      <= en_s && converter_soft_enable;
      end
   end
endmodule : dvs_ctrl
`default_nettype wire

// [tb/dvs_ctrl_checker.sv]
// Port assertions for the voltage scaling control block
`timescale 1ns/1ps
`default_nettype none
module dvs_ctrl_checker (
   // Clock, reset, register port
   input wire logic       clk,
   input wire logic       srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Pins and converter control
   input wire logic       enable_pin,
   input wire logic       output_undervolt,
   input wire logic [5:0] output_step_code,
   input wire logic       power_good_output,
   input wire logic       converter_on,
   input wire logic       light_skip_inductor_opt
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Own copy of the pin synchroniser, so refused writes are known to the cycle
   logic en_q1;
   logic en_q2;
   always_ff @(posedge clk) begin
      if (srst) begin
         en_q1 <= 1'b0;
         en_q2 <= 1'b0;
      end else begin
         en_q1 <= enable_pin;
         en_q2 <= en_q1;
      end
   end
   wire logic vreg = reg_wr && reg_addr < 8'h02 && en_q2;
   property p_rst;
      $fell(srst) |-> reg_rdata == 8'hff && output_step_code == 6'h00
         && !power_good_output && !converter_on && light_skip_inductor_opt;
   endproperty
   property p_unmap; reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'hff; endproperty
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   property p_en; !enable_pin [*4] |-> !converter_on; endproperty
   property p_soft; vreg && !reg_wdata[7] |-> ##2 !converter_on; endproperty
   property p_light; vreg |=> light_skip_inductor_opt == $past(reg_wdata[6]); endproperty
   property p_uv; output_undervolt [*4] |-> !power_good_output; endproperty
   property p_lock; !enable_pin [*6] |-> $stable(light_skip_inductor_opt); endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   a_unmap: assert property (p_unmap) else $error("unmapped read not ff");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_en: assert property (p_en) else $error("on with pin low");
   a_soft: assert property (p_soft) else $error("soft off ignored");
   a_light: assert property (p_light) else $error("shared bit 6 wrong");
   a_uv: assert property (p_uv) else $error("good while low");
   a_lock: assert property (p_lock) else $error("write taken with pin low");
   c_wr: cover property (vreg);
   c_unmap: cover property (reg_rd && reg_addr > 8'h03);
   c_pg: cover property (!power_good_output ##1 power_good_output);
endmodule : dvs_ctrl_checker
bind dvs_ctrl dvs_ctrl_checker u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .enable_pin(enable_pin), .output_undervolt(output_undervolt),
   .output_step_code(output_step_code), .power_good_output(power_good_output),
   .converter_on(converter_on), .light_skip_inductor_opt(light_skip_inductor_opt));
`default_nettype wire

// [tb/host_model.sv]
// Host processor model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // Clock and read data
   input  wire logic       clk,
   input  wire logic [7:0] reg_rdata,
   // Register port
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_wr,
   output var  logic       reg_rd
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // Released lines invert so stale values never pass
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : host_model
`default_nettype wire

// [tb/dvs_ctrl_bench.sv]
// Self-checking bench for the voltage scaling control block
`timescale 1ns/1ps
`default_nettype none
module dvs_ctrl_bench;
   import dvs_pkg::*;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic       sel_pin = 1'b0;
   logic       en_pin = 1'b1;
   logic       undervolt = 1'b0;
   logic       pulsing = 1'b0;
   logic [7:0] addr, wdata, rdata, rv;
   logic       wr, rd, pg, on, opt;
   logic [5:0] code;
   int         num_errors = 0;
   int         n_tests = 0;
   int         cycles = 0;
   always #2.5 clk = ~clk;
   dvs_ctrl #(.STEP_BASE_CYC(4)) u_dut (.clk(clk), .srst(srst), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .voltage_select_pin(sel_pin), .enable_pin(en_pin), .output_undervolt(undervolt),
      .pfm_pulsing(pulsing), .output_step_code(code), .power_good_output(pg),
      .converter_on(on), .light_skip_inductor_opt(opt));
   host_model u_host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      u_host.rd(a, rv);
      chk(rv, exp);
   endtask : rchk
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_cyc
   task automatic print_verdict;
      if (num_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : print_verdict
   // Whole run needs about 350 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic t_reset;
      chk({2'h0, code}, 8'h00);
      rchk(ADDR_FLOOR, 8'hc0);
      rchk(ADDR_ROOF, 8'hd0);
      rchk(ADDR_MODE, MODE_RST);
      rchk(ADDR_RAMP, 8'h07);
      rchk(8'h04, UNMAPPED_READ);
      rchk(8'hff, UNMAPPED_READ);
   endtask : t_reset
   task automatic t_hw;
      u_host.wr(ADDR_RAMP, 8'hc7);
      rchk(ADDR_RAMP, 8'h47);
      chk({2'h0, code}, 8'h00);
      sel_pin = 1'b1;
      wait_cyc(6);
      chk({2'h0, code}, 8'h10);
      u_host.wr(ADDR_FLOOR, 8'hc5);
      wait_cyc(4);
      chk({2'h0, code}, 8'h10);
      u_host.wr(ADDR_ROOF, 8'hd8);
      wait_cyc(4);
      chk({2'h0, code}, 8'h18);
      sel_pin = 1'b0;
      wait_cyc(6);
      chk({2'h0, code}, 8'h05);
      chk({7'h0, pg}, 8'h01);
   endtask : t_hw
   task automatic t_sw;
      u_host.wr(ADDR_RAMP, 8'h07);
      u_host.wr(ADDR_ROOF, 8'he0);
      sel_pin = 1'b1;
      wait_cyc(6);
      chk({2'h0, code}, 8'h05);
      u_host.wr(ADDR_RAMP, 8'h87);
      wait_cyc(4);
      chk({2'h0, code}, 8'h20);
      rchk(ADDR_RAMP, 8'h07);
      sel_pin = 1'b0;
      wait_cyc(6);
      chk({2'h0, code}, 8'h20);
   endtask : t_sw
   task automatic t_ramp(input logic [7:0] roof, input logic [7:0] ctl, input int mid);
      logic [5:0] from;
      from = code;
      u_host.wr(ADDR_ROOF, roof);
      u_host.wr(ADDR_RAMP, ctl);
      wait_cyc(mid);
      chk({7'h0, pg}, 8'h00);
      chk({7'h0, code != from && code != roof[5:0]}, 8'h01);
      for (int i = 0; i < 400 && code !== roof[5:0]; i++) @(negedge clk);
      wait_cyc(3);
      chk({2'h0, code}, {2'h0, roof[5:0]});
      chk({7'h0, pg}, 8'h01);
      rchk(ADDR_RAMP, {1'b0, ctl[6:0]});
   endtask : t_ramp
   task automatic t_pfm;
      u_host.wr(ADDR_MODE, 8'h04);
      u_host.wr(ADDR_ROOF, 8'hc2);
      u_host.wr(ADDR_RAMP, 8'h87);
      wait_cyc(10);
      chk({2'h0, code}, 8'h02);
      chk({7'h0, pg}, 8'h00);
      pulsing = 1'b1;
      wait_cyc(6);
      chk({7'h0, pg}, 8'h01);
      pulsing = 1'b0;
      undervolt = 1'b1;
      wait_cyc(5);
      chk({7'h0, pg}, 8'h00);
      undervolt = 1'b0;
      wait_cyc(5);
      chk({7'h0, pg}, 8'h01);
   endtask : t_pfm
   task automatic t_shared;
      u_host.wr(ADDR_FLOOR, 8'h05);
      wait_cyc(3);
      chk({6'h0, on, opt}, 8'h00);
      rchk(ADDR_ROOF, 8'h02);
      u_host.wr(ADDR_ROOF, 8'hc2);
      wait_cyc(3);
      rchk(ADDR_FLOOR, 8'hc5);
      chk({6'h0, on, opt}, 8'h03);
      en_pin = 1'b0;
      wait_cyc(4);
      chk({7'h0, on}, 8'h00);
      u_host.wr(ADDR_ROOF, 8'h3f);
      en_pin = 1'b1;
      wait_cyc(4);
      rchk(ADDR_ROOF, 8'hc2);
   endtask : t_shared
   initial begin
      wait_cyc(12);
      srst = 1'b0;
      wait_cyc(3);
      t_reset();
      t_hw();
      t_sw();
      t_ramp(8'hc4, 8'h86, 30);
      t_ramp(8'hc8, 8'h85, 12);
      t_pfm();
      t_shared();
      print_verdict();
   end
endmodule : dvs_ctrl_bench
`default_nettype wire
